// >>> core/fism_pkg.sv
// Purpose: Shared constants for the write state machine status reporter
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: Status word is nine bits wide
package fism_pkg;
	// ==========================================
	// Register map
	localparam logic [7:0] FISM_ADDR_STATUS = 8'h00;
	localparam logic [7:0] FISM_ADDR_CMD = 8'h04;
	localparam logic [7:0] FISM_ADDR_CTRL = 8'h08;
	localparam logic [7:0] FISM_ADDR_MODE = 8'h0C;
	// ==========================================
	// Command word fields
	localparam int FISM_CMD_START_BIT = 0;
	localparam int FISM_CMD_OP_LSB = 4;
	localparam int FISM_CMD_BANK_LSB = 8;
	localparam int FISM_CMD_FAIL_BIT = 12;
	localparam int FISM_CMD_PROT_BIT = 13;
	localparam int FISM_CMD_CLEAR_BIT = 16;
	localparam int FISM_CMD_SEQERR_BIT = 17;
	localparam int FISM_CMD_INIT_BIT = 18;
	localparam int FISM_CTRL_VPP_BIT = 0;
	// ==========================================
	// Status word bit positions
	localparam int FISM_SR_DEV = 0;
	localparam int FISM_SR_BANK_LSB = 1;
	localparam int FISM_SR_PROT = 3;
	localparam int FISM_SR_PGM = 4;
	localparam int FISM_SR_ERS = 5;
	localparam int FISM_SR_READY = 7;
	localparam int FISM_SR_SUPPLY = 8;
	// ==========================================
	// Device-level operation codes placed in the bank field
	localparam logic [1:0] FISM_DEV_BLOCK = 2'h0;
	localparam logic [1:0] FISM_DEV_DEVICE = 2'h1;
	localparam logic [1:0] FISM_DEV_NONVOLATILE_CONFIG_MODE = 2'h2;
	localparam logic [1:0] FISM_DEV_INIT = 2'h3;
	localparam logic [31:0] FISM_BUSY_CYCLES = 32'h0000_0010;
	localparam logic [1:0] FISM_RESP_OKAY = 2'h0;
	localparam logic [1:0] FISM_RESP_SLVERR = 2'h2;
	localparam logic [1:0] FISM_RESP_DECERR = 2'h3;
	typedef enum logic [2:0] {
		FISM_OP_PROGRAM = 3'h0,
		FISM_OP_ERASE = 3'h1,
		FISM_OP_BLK_PROT = 3'h2,
		FISM_OP_BLK_UNPROT = 3'h3,
		FISM_OP_DEV_PROT = 3'h4,
		FISM_OP_DEV_UNPROT = 3'h5,
		FISM_OP_NV_PROGRAM = 3'h6,
		FISM_OP_NV_ERASE = 3'h7
	} fism_op_t;
	typedef enum logic [1:0] {
		FISM_ST_READY = 2'h0,
		FISM_ST_BUSY = 2'h1,
		FISM_ST_INIT = 2'h2
	} fism_state_t;
endpackage : fism_pkg

// >>> core/fism_encode.sv
// Purpose: Build the nine-bit status word from machine state
// Assumes: Inputs registered upstream
// Notes: Purely combinational
`timescale 1ns/1ps
module fism_encode (
	input wire logic busy,
	input wire logic dev_level,
	input wire logic [1:0] unit,
	input wire logic prot_err,
	input wire logic pgm_err,
	input wire logic ers_err,
	input wire logic supply_err,
	output logic [8:0] word
);
	always_comb begin
		word = 9'h000;
		word[fism_pkg::FISM_SR_READY] = ~busy;
		// Bank and device bits only meaningful while busy
		if (busy) begin
			word[fism_pkg::FISM_SR_DEV] = dev_level;
			word[fism_pkg::FISM_SR_BANK_LSB +: 2] = unit;
		end
		word[fism_pkg::FISM_SR_PGM] = pgm_err;
		word[fism_pkg::FISM_SR_ERS] = ers_err;
		// Protection error only reported once ready
		word[fism_pkg::FISM_SR_PROT] = prot_err & ~busy;
		word[fism_pkg::FISM_SR_SUPPLY] = supply_err;
	end
endmodule : fism_encode

// >>> core/fism_axil.sv
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: Master keeps valid and payload until accepted
// Notes: Write pulse is one cycle, read data sampled the cycle after address accept
`timescale 1ns/1ps
module fism_axil (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_pulse,
	output logic [7:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	output logic [7:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_ok,
	input wire logic wr_ok
);
	logic aw_have_r;
	logic w_have_r;
	// ==========================================
	// Write channel: address and data in either order
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
			wr_pulse <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else if (ce) begin
			wr_pulse <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				wr_addr <= s_axi_awaddr;
				aw_have_r <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
				w_have_r <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_have_r && w_have_r && !s_axi_bvalid && !wr_pulse) begin
				wr_pulse <= 1'b1;
			end
			if (wr_pulse) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? fism_pkg::FISM_RESP_OKAY : fism_pkg::FISM_RESP_DECERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end
	// ==========================================
	// Read channel
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
			rd_addr <= 8'h00;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				rd_addr <= s_axi_araddr;
				s_axi_arready <= 1'b0;
			end else if (!s_axi_arready && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_ok ? rd_data : 32'h0000_0000;
				s_axi_rresp <= rd_ok ? fism_pkg::FISM_RESP_OKAY : fism_pkg::FISM_RESP_DECERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule : fism_axil

// >>> core/fism_status.sv
// Purpose: Status reporting of the internal write state machine
// Assumes: Operations are launched by software through a command register
// Notes: Busy time is a parameter; failures are requested with the command
// Notes: Protect-pin level is only stored; nothing inside acts on it
`timescale 1ns/1ps
module fism_status #(
	parameter logic [31:0] BUSY_CYCLES = fism_pkg::FISM_BUSY_CYCLES,
	parameter int BANKS = 4
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [8:0] ism_status_word,
	output logic [BANKS-1:0] bank_array_read
);
	// ==========================================
	// Local constants
	localparam logic [3:0] FULL_STRB = 4'hF;
	localparam logic [31:0] CNT_ONE = 32'h0000_0001;
	// Reset word shows ready with no errors; the supply flag follows a cycle later
	localparam logic [8:0] WORD_AT_RESET = 9'h080;
	// ==========================================
	// Bus-side wires
	logic wr_pulse;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_ok;
	logic wr_ok;
	logic [8:0] word_nxt;
	// ==========================================
	// Operation state
	fism_pkg::fism_state_t state_r;
	fism_pkg::fism_op_t op_r;
	logic [1:0] bank_r;
	logic fail_r;
	logic prot_r;
	logic [31:0] cnt_r;
	logic prot_err_r;
	logic pgm_err_r;
	logic ers_err_r;
	logic supply_err_r;
	logic vpp_high_r;
	logic cmd_wr;
	logic start;
	logic busy;
	logic dev_level;
	logic [1:0] unit;
	fism_pkg::fism_op_t cmd_op;
	logic cmd_clear;
	logic cmd_seqerr;
	logic cmd_init;
	logic ctrl_wr;
	logic op_done;
	logic op_fail;

	// ==========================================
	// Decode shared by write and read paths
	function automatic logic addr_known(input logic [7:0] a);
		if (a == fism_pkg::FISM_ADDR_STATUS) begin
			return 1'b1;
		end else if (a == fism_pkg::FISM_ADDR_CMD) begin
			return 1'b1;
		end else if (a == fism_pkg::FISM_ADDR_CTRL) begin
			return 1'b1;
		end else if (a == fism_pkg::FISM_ADDR_MODE) begin
			return 1'b1;
		end else begin
			return 1'b0;
		end
	endfunction : addr_known

	// Program-type operations report through the program-error bit
	function automatic logic is_pgm_kind(input fism_pkg::fism_op_t op);
		return (op == fism_pkg::FISM_OP_PROGRAM) || (op == fism_pkg::FISM_OP_BLK_PROT) ||
			(op == fism_pkg::FISM_OP_DEV_PROT) || (op == fism_pkg::FISM_OP_NV_PROGRAM);
	endfunction : is_pgm_kind

	// ==========================================
	// Bus front end
	fism_axil u_axil (
		.sys_clk(sys_clk),
		.rst(rst),
		.ce(ce),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_pulse(wr_pulse),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(rd_ok),
		.wr_ok(wr_ok)
	);

	assign wr_ok = addr_known(wr_addr);
	assign rd_ok = addr_known(rd_addr);
	// Partial-word command writes are ignored so a stray byte cannot start work
	assign cmd_wr = wr_pulse && (wr_addr == fism_pkg::FISM_ADDR_CMD) && (wr_strb == FULL_STRB);
	assign cmd_clear = cmd_wr && wr_data[fism_pkg::FISM_CMD_CLEAR_BIT];
	assign cmd_seqerr = cmd_wr && wr_data[fism_pkg::FISM_CMD_SEQERR_BIT];
	assign cmd_init = cmd_wr && wr_data[fism_pkg::FISM_CMD_INIT_BIT];
	assign ctrl_wr = wr_pulse && (wr_addr == fism_pkg::FISM_ADDR_CTRL) && wr_strb[0];
	assign cmd_op = fism_pkg::fism_op_t'(wr_data[fism_pkg::FISM_CMD_OP_LSB +: 3]);
	assign busy = (state_r != fism_pkg::FISM_ST_READY);
	// Starts while busy are dropped; the sequence error bits are set only by the command's seqerr bit
	assign start = cmd_wr && wr_data[fism_pkg::FISM_CMD_START_BIT];
	// Last busy cycle; state and supply flag leave on the same edge
	assign op_done = (cnt_r <= CNT_ONE);
	assign op_fail = (state_r == fism_pkg::FISM_ST_BUSY) && fail_r;

	// ==========================================
	// Read mux
	always_comb begin
		// Command register is write-only and reads as zero
		rd_data = 32'h0000_0000;
		if (rd_addr == fism_pkg::FISM_ADDR_STATUS) begin
			rd_data[8:0] = ism_status_word;
		end else if (rd_addr == fism_pkg::FISM_ADDR_CTRL) begin
			rd_data[fism_pkg::FISM_CTRL_VPP_BIT] = vpp_high_r;
		end else if (rd_addr == fism_pkg::FISM_ADDR_MODE) begin
			rd_data[BANKS-1:0] = bank_array_read;
		end else begin
			rd_data = 32'h0000_0000;
		end
	end

	// ==========================================
	// Protect pin high-voltage level, held as a control bit
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			vpp_high_r <= 1'b0;
		end else if (ce && ctrl_wr) begin
			vpp_high_r <= wr_data[fism_pkg::FISM_CTRL_VPP_BIT];
		end
	end

	// ==========================================
	// Operation sequencer
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_r <= fism_pkg::FISM_ST_READY;
			op_r <= fism_pkg::FISM_OP_PROGRAM;
			bank_r <= 2'h0;
			fail_r <= 1'b0;
			prot_r <= 1'b0;
			cnt_r <= 32'h0000_0000;
		end else if (ce) begin
			case (state_r)
				fism_pkg::FISM_ST_READY: begin
					// Init takes priority over a start in the same word
					if (cmd_init) begin
						state_r <= fism_pkg::FISM_ST_INIT;
						cnt_r <= BUSY_CYCLES;
					end else if (start) begin
						state_r <= fism_pkg::FISM_ST_BUSY;
						op_r <= cmd_op;
						bank_r <= wr_data[fism_pkg::FISM_CMD_BANK_LSB +: 2];
						fail_r <= wr_data[fism_pkg::FISM_CMD_FAIL_BIT];
						prot_r <= wr_data[fism_pkg::FISM_CMD_PROT_BIT];
						cnt_r <= BUSY_CYCLES;
					end
				end
				fism_pkg::FISM_ST_BUSY, fism_pkg::FISM_ST_INIT: begin
					if (op_done) begin
						state_r <= fism_pkg::FISM_ST_READY;
					end else begin
						cnt_r <= cnt_r - CNT_ONE;
					end
				end
				default: begin
					state_r <= fism_pkg::FISM_ST_READY;
				end
			endcase
		end
	end

	// ==========================================
	// Where the busy operation reports in the bank field
	always_comb begin
		// Idle and init both fall through to the init code; only busy decodes the op
		dev_level = 1'b1;
		unit = fism_pkg::FISM_DEV_INIT;
		if (state_r == fism_pkg::FISM_ST_BUSY) begin
			case (op_r)
				fism_pkg::FISM_OP_PROGRAM, fism_pkg::FISM_OP_ERASE: begin
					dev_level = 1'b0;
					unit = bank_r;
				end
				fism_pkg::FISM_OP_BLK_PROT, fism_pkg::FISM_OP_BLK_UNPROT: begin
					unit = fism_pkg::FISM_DEV_BLOCK;
				end
				fism_pkg::FISM_OP_DEV_PROT, fism_pkg::FISM_OP_DEV_UNPROT: begin
					unit = fism_pkg::FISM_DEV_DEVICE;
				end
				default: begin
					unit = fism_pkg::FISM_DEV_NONVOLATILE_CONFIG_MODE;
				end
			endcase
		end
	end

	// ==========================================
	// Sticky error flags; a setting event wins over the clear
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prot_err_r <= 1'b0;
			pgm_err_r <= 1'b0;
			ers_err_r <= 1'b0;
		end else if (ce) begin
			if (cmd_clear) begin
				prot_err_r <= 1'b0;
				pgm_err_r <= 1'b0;
				ers_err_r <= 1'b0;
			end
			// Failure appears while busy, once the operation is under way
			if (op_fail) begin
				if (is_pgm_kind(op_r)) begin
					pgm_err_r <= 1'b1;
				end else begin
					ers_err_r <= 1'b1;
				end
				if (prot_r) begin
					prot_err_r <= 1'b1;
				end
			end
			// Later assignments win, so a set in the clear cycle survives
			if (cmd_seqerr) begin
				pgm_err_r <= 1'b1;
				ers_err_r <= 1'b1;
				if (wr_data[fism_pkg::FISM_CMD_PROT_BIT]) begin
					prot_err_r <= 1'b1;
				end
			end
		end
	end

	// ==========================================
	// Supply error: set from reset until an initialization cycle completes
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			supply_err_r <= 1'b1;
		end else if (ce && state_r == fism_pkg::FISM_ST_INIT && op_done) begin
			supply_err_r <= 1'b0;
		end
	end

	// ==========================================
	// Per-bank array read mode after the operation ends
	genvar g;
	generate
		for (g = 0; g < BANKS; g++) begin : g_bank
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					bank_array_read[g] <= 1'b1;
				end else if (ce) begin
					// Device-level work leaves every bank readable
					if (state_r == fism_pkg::FISM_ST_BUSY && !dev_level && bank_r == 2'(g)) begin
						bank_array_read[g] <= 1'b0;
					end else begin
						bank_array_read[g] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	// ==========================================
	// Status word
	fism_encode u_encode (
		.busy(busy),
		.dev_level(dev_level),
		.unit(unit),
		.prot_err(prot_err_r),
		.pgm_err(pgm_err_r),
		.ers_err(ers_err_r),
		.supply_err(supply_err_r),
		.word(word_nxt)
	);
	// Registered so the port never shows a decode glitch

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ism_status_word <= WORD_AT_RESET;
		end else if (ce) begin
			ism_status_word <= word_nxt;
		end
	end
endmodule : fism_status

// >>> verif/fism_status_props.sv
// Purpose: Port-level checks on the status reporter
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to fism_status below
`timescale 1ns/1ps
module fism_status_props #(
	parameter int BANKS = 4
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [8:0] ism_status_word,
	input wire logic [BANKS-1:0] bank_array_read
);
	wire logic [8:0] sw = ism_status_word;
	logic [3:0] since_clr_r;
	// ==========================================
	// Age of the last clear write, saturating
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			since_clr_r <= 4'hF;
		end else if (s_axi_wvalid && s_axi_wready && s_axi_wdata[fism_pkg::FISM_CMD_CLEAR_BIT]) begin
			since_clr_r <= 4'h0;
		end else if (since_clr_r != 4'hF) begin
			since_clr_r <= since_clr_r + 4'h1;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ==========================================
	// Status word
	ready_bank_zero_a: assert property (sw[7] && !sw[8] |-> sw[2:0] == 3'h0)
		else $error("bank bits set while ready");
	busy_clean_a: assert property (!sw[7] && !sw[8] |-> !sw[3] && !sw[6])
		else $error("protection or reserved bit set while busy");
	err_sticky_a: assert property (($fell(sw[4]) || $fell(sw[5])) && !sw[8]
		&& !$past(sw[8]) |-> since_clr_r <= 4'h5) else $error("error bit dropped without clear");
	supply_clear_a: assert property ($fell(sw[8]) |-> sw[7])
		else $error("supply flag cleared while busy");
	array_ready_a: assert property ($rose(sw[7]) && !sw[8] |-> ##[0:2]
		bank_array_read == {BANKS{1'b1}}) else $error("bank not in array read");
	// ==========================================
	// Register bus
	b_after_w_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##3 s_axi_bvalid) else $error("write response late");
	r_after_ar_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read response late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
endmodule : fism_status_props
bind fism_status fism_status_props #(.BANKS(BANKS)) u_props (.sys_clk(sys_clk), .rst(rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.ism_status_word(ism_status_word), .bank_array_read(bank_array_read));

// >>> verif/fism_host_model.sv
// Purpose: Controller model issuing register cycles
// Assumes: One write and one read at a time
// Notes: Released payload shows the inverse of the last value
`timescale 1ns/1ps
module fism_host_model (
	input wire logic sys_clk,
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
	end
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		end
		while (s_axi_bvalid !== 1'b1) begin
			@(posedge sys_clk);
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge sys_clk);
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= ~a;
		while (s_axi_rvalid !== 1'b1) begin
			@(posedge sys_clk);
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge sys_clk);
	endtask : axi_read
endmodule : fism_host_model

// >>> verif/tb.sv
// Purpose: Self-checking bench for the status reporter
// Assumes: Busy time lengthened to 40 cycles
// Notes: Status is read on the port and through the bus
`timescale 1ns/1ps
module tb;
	logic sys_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ce;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, bank_array_read;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [8:0] ism_status_word;
	int error_cnt;
	int checks_done;
	fism_status #(.BUSY_CYCLES(32'h0000_0028)) u_dut (.sys_clk, .rst, .ce, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ism_status_word, .bank_array_read);
	fism_host_model u_host (.sys_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	function automatic logic [31:0] op_word(int op, int b, logic f, logic p);
		return 32'h0000_0001 | 32'(op << 4) | 32'(b << 8) | {18'h0, p, f, 12'h000};
	endfunction : op_word
	// ==========================================
	// Command, then busy code, then final ready code
	task automatic cmd(input logic [31:0] d, input logic [8:0] busy_exp, input logic [8:0] rdy_exp);
		logic [31:0] rd;
		logic [1:0] rr;
		int n;
		u_host.axi_write(fism_pkg::FISM_ADDR_CMD, d, rr);
		check("bresp", 32'(rr), 32'(fism_pkg::FISM_RESP_OKAY));
		repeat (4) @(posedge sys_clk);
		check("busy code", 32'(ism_status_word), 32'(busy_exp));
		n = 0;
		while (ism_status_word[7] !== 1'b1 && n < 300) begin
			@(posedge sys_clk);
			n++;
		end
		check("ready code", 32'(ism_status_word), 32'(rdy_exp));
		check("array read", 32'(bank_array_read), 32'h0000_000F);
		u_host.axi_read(fism_pkg::FISM_ADDR_STATUS, rd, rr);
		check("status reg", rd, 32'(rdy_exp));
		check("status rresp", 32'(rr), 32'(fism_pkg::FISM_RESP_OKAY));
	endtask : cmd
	task automatic t_reset();
		logic [31:0] rd;
		logic [1:0] rr;
		repeat (2) @(posedge sys_clk);
		check("reset status", 32'(ism_status_word), 32'h0000_0180);
		u_host.axi_read(fism_pkg::FISM_ADDR_MODE, rd, rr);
		check("mode reg", rd, 32'h0000_000F);
		u_host.axi_read(8'h10, rd, rr);
		check("unmapped resp", 32'(rr), 32'(fism_pkg::FISM_RESP_DECERR));
		check("unmapped data", rd, 32'h0000_0000);
		cmd(32'h0004_0000, 9'h107, 9'h080);
	endtask : t_reset
	// ==========================================
	// Every operation, bank, failure and protection cause
	task automatic t_ops();
		logic [8:0] dev_busy [8] = '{9'h000, 9'h000, 9'h001, 9'h001, 9'h003, 9'h003, 9'h005, 9'h005};
		logic [8:0] base;
		logic [8:0] be;
		logic [8:0] ee;
		logic [1:0] rr;
		u_host.axi_write(fism_pkg::FISM_ADDR_CTRL, 32'h0000_0001, rr);
		check("ctrl bresp", 32'(rr), 32'(fism_pkg::FISM_RESP_OKAY));
		for (int op = 0; op < 8; op++) begin
			for (int b = 0; b < 4; b++) begin
				for (int v = 0; v < 3; v++) begin
					if (op < 2 || b == 0) begin
						base = (op < 2) ? 9'(b << 1) : dev_busy[op];
						be = (op % 2) ? 9'h020 : 9'h010;
						ee = (op % 2) ? 9'h0A0 : 9'h090;
						if (v == 0) begin
							cmd(op_word(op, b, 1'b0, 1'b0), base, 9'h080);
						end else begin
							ee = ee | ((v == 2) ? 9'h008 : 9'h000);
							cmd(op_word(op, b, 1'b1, v == 2), base | be, ee);
							cmd(32'h0001_0000, 9'h080, 9'h080);
						end
					end
				end
			end
		end
	endtask : t_ops
	task automatic t_sticky();
		cmd(op_word(0, 0, 1'b1, 1'b0), 9'h010, 9'h090);
		cmd(op_word(0, 1, 1'b0, 1'b0), 9'h012, 9'h090);
		cmd(32'h0001_0000, 9'h080, 9'h080);
	endtask : t_sticky
	task automatic t_seq_err();
		cmd(32'h0002_0000, 9'h0B0, 9'h0B0);
		cmd(32'h0001_0000, 9'h080, 9'h080);
		cmd(32'h0002_2000, 9'h0B8, 9'h0B8);
		cmd(32'h0001_0000, 9'h080, 9'h080);
	endtask : t_seq_err
	// ==========================================
	// Clock enable low holds a running erase where it stands
	task automatic t_freeze();
		logic [31:0] rd;
		logic [1:0] rr;
		int n;
		u_host.axi_write(fism_pkg::FISM_ADDR_CMD, op_word(1, 2, 1'b0, 1'b0), rr);
		repeat (4) @(posedge sys_clk);
		u_host.axi_read(fism_pkg::FISM_ADDR_MODE, rd, rr);
		check("busy bank mode", rd, 32'h0000_000B);
		ce <= 1'b0;
		repeat (60) @(posedge sys_clk);
		check("frozen code", 32'(ism_status_word), 32'h0000_0004);
		check("frozen mode", 32'(bank_array_read), 32'h0000_000B);
		ce <= 1'b1;
		n = 0;
		while (ism_status_word[7] !== 1'b1 && n < 300) begin
			@(posedge sys_clk);
			n++;
		end
		check("thawed code", 32'(ism_status_word), 32'h0000_0080);
		check("held span", 32'(n > 20), 32'h0000_0001);
		check("thawed mode", 32'(bank_array_read), 32'h0000_000F);
	endtask : t_freeze
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Whole run is near 2800 cycles; seven times that is a hang
	initial begin
		#200000;
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		error_cnt = 0;
		checks_done = 0;
		ce = 1'b1;
		rst = 1'b1;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_reset();
		t_ops();
		t_sticky();
		t_seq_err();
		t_freeze();
		tally_and_finish();
	end
endmodule : tb
